// ===== hw/sram_host_map.svh
// Timing counts, widths and pin levels for the asynchronous static memory host port.
// Assumes a single 100 MHz clock; all counts are whole cycles of that clock.
`ifndef SRAM_HOST_MAP_SVH
`define SRAM_HOST_MAP_SVH

`define SRAM_ADDR_W          19
`define SRAM_DATA_W          16
`define SRAM_LANE_W          8
`define SRAM_TMR_W           4

`define SRAM_CLK_NS          10
`define SRAM_CYC(ns)         (((ns) + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS)

// Minimum and maximum figures for the 45 ns grade, in nanoseconds.
`define SRAM_T_AA_NS         45
`define SRAM_T_RC_NS         45
`define SRAM_T_SD_NS         25
`define SRAM_T_HZWE_NS       18
`define SRAM_T_PWE_NS        35
`define SRAM_T_HZOE_NS       18

// The strobe pulse covers set-up plus strobe-to-float rather than the pulse width.
`define SRAM_WR_PULSE_NS     (`SRAM_T_SD_NS + `SRAM_T_HZWE_NS)
`define SRAM_RD_CYC          `SRAM_CYC(`SRAM_T_AA_NS)
`define SRAM_WR_CYC          `SRAM_CYC(`SRAM_WR_PULSE_NS)
`define SRAM_TURN_CYC        `SRAM_CYC(`SRAM_T_HZOE_NS)

`define SRAM_LANES_OFF       2'h3

`endif

// ===== hw/sram_host_pkg.sv
// Types shared by the static memory host port.
// Assumes the constant header is on the include path.
`include "sram_host_map.svh"

package sram_host_pkg;

  typedef struct packed {
    logic                      write;
    logic [`SRAM_ADDR_W-1:0]   addr;
    logic [`SRAM_DATA_W-1:0]   wdata;
    logic [1:0]                lane_en;
  } host_req_t;

  typedef struct packed {
    logic [`SRAM_ADDR_W-1:0]   addr;
    logic                      primary_select_n;
    logic                      secondary_select;
    logic                      write_strobe_n;
    logic                      output_gate_n;
    logic                      upper_lane_en_n;
    logic                      lower_lane_en_n;
  } sram_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_RD_WAIT  = 3'h1,
    ST_RD_END   = 3'h3,
    ST_TURN     = 3'h2,
    ST_WR_SETUP = 3'h4,
    ST_WR_PULSE = 3'h5,
    ST_WR_HOLD  = 3'h7
  } host_state_t;

endpackage

// ===== hw/sram_host_timer.sv
// Down counter that times the read wait, write pulse and turnaround phases of a memory cycle.
// Assumes the controller loads it on the edge that enters a timed phase.
`timescale 1ns/1ps
`include "sram_host_map.svh"

module sram_host_timer (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire logic                   load,
  input  wire logic [`SRAM_TMR_W-1:0] load_value,
  output logic                        done
);

  logic [`SRAM_TMR_W-1:0] count;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 4'h0;
    end else if (load) begin
      count <= load_value;
    end else if (count != 4'h0) begin
      count <= count - 4'h1;
    end
  end

  assign done = (count == 4'h0);

endmodule

// ===== hw/sram_host_ctrl.sv
// Host controller that runs read and write cycles on an asynchronous static memory.
// Assumes the memory pins are wired straight to these ports and data_in is already synchronous.
`timescale 1ns/1ps
`include "sram_host_map.svh"

module sram_host_ctrl (
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic                    req_valid,
  input  sram_host_pkg::host_req_t     req,
  output logic                         req_ready,
  output logic                         rsp_valid,
  output logic [`SRAM_DATA_W-1:0]      rsp_data,
  output sram_host_pkg::sram_ctl_t     mem_ctl,
  output logic [`SRAM_DATA_W-1:0]      data_out,
  output logic                         data_oe,
  input  wire logic [`SRAM_DATA_W-1:0] data_in
);
  import sram_host_pkg::*;

  // ------------------------------------------------------------------
  // Pin levels for each state
  // ------------------------------------------------------------------

  function automatic sram_ctl_t pins_for(input host_state_t st, input host_req_t r);
    sram_ctl_t p;
    p.addr             = r.addr;
    p.primary_select_n = 1'b1;
    p.secondary_select = 1'b0;
    p.write_strobe_n   = 1'b1;
    p.output_gate_n    = 1'b1;
    p.upper_lane_en_n  = 1'b1;
    p.lower_lane_en_n  = 1'b1;
    if (st != ST_IDLE && st != ST_TURN) begin
      // Address, selects and lanes move on the same edge.
      p.primary_select_n = 1'b0;
      p.secondary_select = 1'b1;
      p.upper_lane_en_n  = ~r.lane_en[1];
      p.lower_lane_en_n  = ~r.lane_en[0];
    end
    if (st == ST_RD_WAIT || st == ST_RD_END) begin
      p.output_gate_n = 1'b0;
    end
    // Only the pulse state pulls the strobe low, so reads keep it high.
    if (st == ST_WR_PULSE) begin
      p.write_strobe_n = 1'b0;
    end
    return p;
  endfunction

  function automatic logic drives_bus(input host_state_t st);
    return (st == ST_WR_SETUP) || (st == ST_WR_PULSE) || (st == ST_WR_HOLD);
  endfunction

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------

  host_state_t              state;
  host_state_t              next_state;
  host_req_t                cur;
  logic                     wr_pend;
  logic                     tmr_done;
  logic                     tmr_load;
  logic [`SRAM_TMR_W-1:0]   tmr_value;

  wire logic      accept     = req_valid && req_ready;
  wire host_req_t next_cur   = accept ? req : cur;
  wire logic      next_pend  = (state == ST_RD_END) ? (accept && req.write)
                             : ((state == ST_TURN) ? wr_pend : 1'b0);
  wire logic      rd_capture = (state == ST_RD_WAIT) && tmr_done;
  wire logic [`SRAM_DATA_W-1:0] lane_mask =
    {{`SRAM_LANE_W{cur.lane_en[1]}}, {`SRAM_LANE_W{cur.lane_en[0]}}};

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = req.write ? ST_WR_SETUP : ST_RD_WAIT;
        end
      end
      ST_RD_WAIT: begin
        if (tmr_done) begin
          next_state = ST_RD_END;
        end
      end
      ST_RD_END: begin
        // A read follows with selects held; anything else releases the bus first.
        if (accept && !req.write) begin
          next_state = ST_RD_WAIT;
        end else begin
          next_state = ST_TURN;
        end
      end
      ST_TURN: begin
        if (tmr_done) begin
          next_state = wr_pend ? ST_WR_SETUP : ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        next_state = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        if (tmr_done) begin
          next_state = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  assign tmr_load = (next_state != state || state == ST_RD_END)
                 && (next_state == ST_RD_WAIT || next_state == ST_WR_PULSE
                  || next_state == ST_TURN);

  // The strobe pulse length covers set-up plus strobe-to-float.
  assign tmr_value = (next_state == ST_RD_WAIT)  ? 4'(`SRAM_RD_CYC - 1)
                   : (next_state == ST_WR_PULSE) ? 4'(`SRAM_WR_CYC - 1)
                   : 4'(`SRAM_TURN_CYC - 1);

  sram_host_timer u_timer (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .load       (tmr_load),
    .load_value (tmr_value),
    .done       (tmr_done)
  );

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= ST_IDLE;
      cur     <= '0;
      wr_pend <= 1'b0;
    end else begin
      state   <= next_state;
      cur     <= next_cur;
      wr_pend <= next_pend;
    end
  end

  // ------------------------------------------------------------------
  // Registered pins and answers
  // ------------------------------------------------------------------

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ctl  <= '{addr: '0, primary_select_n: 1'b1, secondary_select: 1'b0,
                    write_strobe_n: 1'b1, output_gate_n: 1'b1, upper_lane_en_n: 1'b1,
                    lower_lane_en_n: 1'b1};
      data_out <= 16'h0000;
      data_oe  <= 1'b0;
    end else begin
      mem_ctl  <= pins_for(next_state, next_cur);
      // Data is held through the hold state past the strobe's rising edge.
      data_out <= next_cur.wdata;
      // The gate is high whenever the bus is driven, and turn states follow reads.
      data_oe  <= drives_bus(next_state);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
    end else begin
      req_ready <= (next_state == ST_IDLE) || (next_state == ST_RD_END);
      rsp_valid <= rd_capture;
      if (rd_capture) begin
        rsp_data <= data_in & lane_mask;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------

  sequence s_strobe_pulse;
    !mem_ctl.write_strobe_n [*5];
  endsequence

  sequence s_read_window;
    !mem_ctl.output_gate_n [*5];
  endsequence

  a_write_pulse_len: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $fell(mem_ctl.write_strobe_n) |-> s_strobe_pulse ##1 mem_ctl.write_strobe_n)
    else $error("write strobe pulse is not five cycles");

  a_write_data_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(mem_ctl.write_strobe_n) |-> data_oe && $stable(data_out) && !mem_ctl.primary_select_n)
    else $error("write data or select moved at write end");

  a_write_data_setup: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !mem_ctl.write_strobe_n |-> data_oe && $stable(data_out) && $stable(mem_ctl.addr))
    else $error("write data or address changed during strobe");

  a_select_release: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(mem_ctl.primary_select_n) |-> mem_ctl.write_strobe_n
      && $past(mem_ctl.write_strobe_n))
    else $error("selects released while strobe low");

  a_bus_no_fight: assert property (
    @(posedge mclk) disable iff (!rst_b)
    data_oe |-> mem_ctl.output_gate_n && $past(mem_ctl.output_gate_n))
    else $error("host drives data while output gate low");

  a_bus_turnaround: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(mem_ctl.output_gate_n) |-> !data_oe [*2])
    else $error("bus driven before turnaround elapsed");

  a_read_strobe_high: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !mem_ctl.output_gate_n |-> mem_ctl.write_strobe_n)
    else $error("write strobe low during read");

  a_read_answer: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $fell(mem_ctl.output_gate_n) |-> s_read_window ##1 rsp_valid)
    else $error("read answer not after five cycles");

  a_select_together: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $fell(mem_ctl.primary_select_n) |-> $rose(mem_ctl.secondary_select)
      && mem_ctl.addr == cur.addr)
    else $error("selects or address not asserted together");

endmodule

// ===== testbench/sram_mem_model.sv
// Behavioural asynchronous static memory facing the host port's pins.
// Assumes the bench resolves the shared data wire from both drive enables.
`timescale 1ns/1ps
`include "sram_host_map.svh"

module sram_mem_model #(
  parameter int ACCESS_NS = 45
) (
  input  sram_host_pkg::sram_ctl_t     ctl,
  input  wire logic [`SRAM_DATA_W-1:0] pins,
  output logic [`SRAM_DATA_W-1:0]      rd_data,
  output logic [1:0]                   rd_en
);
  import sram_host_pkg::*;
  logic [15:0] mem [int];
  logic [15:0] wd;
  logic [15:0] old;
  logic [1:0]  wl;
  logic [1:0]  lanes;
  logic        sel;
  logic        wr_on;
  logic        wrote = 1'b0;
  int          wa;

  assign lanes = ~{ctl.upper_lane_en_n, ctl.lower_lane_en_n};
  assign sel   = !ctl.primary_select_n && ctl.secondary_select && lanes != 2'h0;
  assign wr_on = sel && !ctl.write_strobe_n;
  assign rd_en = (sel && ctl.write_strobe_n && !ctl.output_gate_n) ? lanes : 2'h0;

  // Data settles only after the access time, so an early sample shows stale data.
  // A landed write also refreshes the word of an address that did not move.
  always @(ctl.addr or wrote) begin
    rd_data <= #(ACCESS_NS) mem.exists(int'(ctl.addr)) ? mem[int'(ctl.addr)] : 16'h0;
  end

  always @* begin
    if (wr_on) begin
      wa = int'(ctl.addr);
      wl = lanes;
      wd = pins;
    end
  end

  // The write lands when the overlap of both selects, the strobe and any lane enable ends.
  always @(negedge wr_on) begin
    old = mem.exists(wa) ? mem[wa] : 16'h0;
    mem[wa] = {wl[1] ? wd[15:8] : old[15:8], wl[0] ? wd[7:0] : old[7:0]};
    wrote   = ~wrote;
  end
endmodule

// ===== testbench/tb_async_sram_byte_lane_port.sv
// Self-checking bench for the static memory host port with a reference word store.
// Assumes the design files and constant header are on the include path.
`timescale 1ns/1ps
`include "sram_host_map.svh"

module tb_async_sram_byte_lane_port;
  import sram_host_pkg::*;
  logic        mclk;
  logic        rst_b;
  logic        req_valid;
  host_req_t   req;
  logic        req_ready;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  sram_ctl_t   mem_ctl;
  logic [15:0] data_out;
  logic        data_oe;
  logic [15:0] data_in;
  logic [15:0] rd_data;
  logic [1:0]  rd_en;
  logic [15:0] last_pins;
  logic [15:0] ref_mem [int];
  logic [15:0] exp_d [$];
  int          exp_c [$];
  int          cyc = 0;
  int          low_cnt = 0;
  logic        prev_rd;
  int          n_errors;
  int          n_compared;
  int          seed;

  sram_host_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_ctl(mem_ctl),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  sram_mem_model u_mem (.ctl(mem_ctl), .pins(data_in), .rd_data(rd_data), .rd_en(rd_en));

  // A floating lane shows the inverse of its last level rather than a settled value.
  assign data_in = data_oe ? data_out : {rd_en[1] ? rd_data[15:8] : ~last_pins[15:8],
                                         rd_en[0] ? rd_data[7:0] : ~last_pins[7:0]};

  always @(posedge mclk) begin
    last_pins <= data_in;
    cyc       <= cyc + 1;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_ready(output int k);
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (req_ready !== 1'b1 && k < 40);
    if (req_ready !== 1'b1) begin
      n_errors++;
      end_sim();
    end
  endtask

  // Offers one request at a rising edge; returns at the edge that takes a read, or at the first edge after a write has finished.
  task automatic issue(input logic w, input logic [18:0] a, input logic [15:0] d,
                       input logic [1:0] l);
    int          k;
    int          tc;
    logic [15:0] v;
    req_valid <= 1'b1;
    req       <= '{write: w, addr: a, wdata: d, lane_en: l};
    wait_ready(k);
    tc = cyc;
    @(posedge mclk);
    v = ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 16'h0;
    if (w) begin
      ref_mem[int'(a)] = {l[1] ? d[15:8] : v[15:8], l[0] ? d[7:0] : v[7:0]};
      req_valid <= 1'b0;
      wait_ready(k);
      // A write taken straight after a read first waits out the bus turnaround.
      chk("write cycle length", k, (prev_rd ? `SRAM_TURN_CYC : 0) + `SRAM_WR_CYC + 3);
      prev_rd = 1'b0;
      @(posedge mclk);
    end else begin
      prev_rd = 1'b1;
      exp_d.push_back({l[1] ? v[15:8] : 8'h0, l[0] ? v[7:0] : 8'h0});
      exp_c.push_back(tc + 6);
    end
  endtask

  always @(negedge mclk) begin
    if (rst_b) begin
      chk("data bus clash", data_oe && rd_en != 2'h0, 0);
      if (!mem_ctl.output_gate_n) chk("strobe during read", mem_ctl.write_strobe_n, 1);
      if (!mem_ctl.write_strobe_n) begin
        low_cnt++;
      end else if (low_cnt != 0) begin
        chk("strobe width", low_cnt, `SRAM_WR_CYC);
        low_cnt = 0;
      end
      if (rsp_valid && exp_d.size() != 0) begin
        chk("read data", rsp_data, exp_d.pop_front());
        chk("read latency", cyc, exp_c.pop_front());
      end else if (rsp_valid) begin
        chk("unexpected response", 1, 0);
      end
    end
  end

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    logic [18:0] a;
    seed      = 32'hBA37;
    rst_b     = 1'b0;
    req_valid = 1'b0;
    req       = '0;
    prev_rd   = 1'b0;
    n_errors  = 0;
    n_compared = 0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk("ready after reset", req_ready, 1);
    chk("pins after reset", {mem_ctl, data_oe}, {19'h0, 6'h2F, 1'b0});
    @(posedge mclk);
    for (int i = 0; i < 400; i++) begin
      a = 19'($random(seed)) & 19'h70007;
      issue(i < 16 || $random(seed) % 3 == 0, a, 16'($random(seed)), 2'($random(seed)));
      if ($random(seed) % 5 == 0) begin
        req_valid <= 1'b0;
        repeat (3) @(posedge mclk);
      end
    end
    req_valid <= 1'b0;
    repeat (12) @(posedge mclk);
    chk("reads left unanswered", exp_d.size(), 0);
    end_sim();
  end
endmodule
